// >>> verilog/ngrm_defines.vh
// Offsets, field positions and reset values of the identifier and ROM map registers
`ifndef NGRM_DEFINES_VH
`define NGRM_DEFINES_VH

`define NGRM_ADDR_W           8
`define NGRM_OFS_ID_UPPER     8'h24
`define NGRM_OFS_ID_LOWER     8'h28
`define NGRM_OFS_ROM_MAP      8'h34
`define NGRM_OFS_LOAD_STATUS  8'h30
`define NGRM_ID_RESET         32'h0000_0000
`define NGRM_ROM_MAP_RESET    22'h00_0000
`define NGRM_ROM_BASE_LSB     10
`define NGRM_ROM_LO_W         10
`define NGRM_ROM_WIN_LO       48'hffff_f000_0400
`define NGRM_ROM_WIN_HI       48'hffff_f000_07ff
`define NGRM_STAT_LOCKED      0
`define NGRM_STAT_EEPROM      1

`endif

// >>> verilog/ngrm_rom_map.v
// Translates configuration ROM quadlet reads into host memory addresses
`timescale 1ns/100ps
`default_nettype none
`include "ngrm_defines.vh"

module ngrm_rom_map (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        reset_i,
    // Mapping base from the register bank
    input  wire [21:0] rom_image_base_i,
    // Request from the receive decoder
    input  wire        req_valid_i,
    input  wire        req_quadlet_i,
    input  wire [47:0] req_offset_i,
    // Translated answer, one cycle later
    output reg         map_valid_o,
    output reg  [31:0] map_addr_o
);

    wire in_window;
    wire [31:0] sum;

    assign in_window = (req_offset_i >= `NGRM_ROM_WIN_LO) &&
                       (req_offset_i <= `NGRM_ROM_WIN_HI);
    // Base has zero low bits, so adding the low offset bits cannot carry
    assign sum = {rom_image_base_i, 10'h000} +
                 {22'h00_0000, req_offset_i[`NGRM_ROM_LO_W-1:0]};

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            map_valid_o <= 1'b0;
            map_addr_o  <= 32'h0000_0000;
        end else begin
            map_valid_o <= req_valid_i & req_quadlet_i & in_window;
            if (req_valid_i & req_quadlet_i & in_window) begin
                map_addr_o <= sum;
            end
        end
    end

endmodule
`default_nettype wire

// >>> verilog/ngrm_regs.v
// Unique identifier and configuration ROM mapping register bank
//
// What this block does
// - Hardware reset clears both identifier registers to zero, an invalid value.
// - With an EEPROM present, fill identifier registers from it after bus reset.
// - After loading, identifier registers are locked until next hardware reset.
// - Upper identifier holds bits 63..32: maker field and upper serial.
// - Lower identifier holds bits 31..0: lower part serial.
// - Lower identifier resets, loads and locks like the upper one.
// - ROM window quadlet reads map to base plus offset low ten bits.
// - Mapping register bits 9..0 are read-only zero.
`timescale 1ns/100ps
`default_nettype none
`include "ngrm_defines.vh"

module ngrm_regs (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        reset_i,
    // Register port
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // Bus reset and EEPROM loader (pins, synchronised here)
    input  wire        bus_reset_in_i,
    input  wire        eeprom_present_i,
    input  wire        eeprom_load_i,
    input  wire [63:0] eeprom_id_i,
    // Configuration ROM read translation
    input  wire        req_valid_i,
    input  wire        req_quadlet_i,
    input  wire [47:0] req_offset_i,
    output wire        map_valid_o,
    output wire [31:0] map_addr_o,
    // Identifier state
    output wire        id_locked_o,
    output wire [63:0] unique_id_o
);

    // Idle: waiting for bus reset; arm: bus reset seen; load: released,
    // awaiting loader; lock: contents frozen until hardware reset
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ARM  = 4'b0010;
    localparam [3:0] ST_LOAD = 4'b0100;
    localparam [3:0] ST_LOCK = 4'b1000;

    // Bus reset, EEPROM present, load strobe and the 64 identifier bits
    localparam SYNC_W = 67;

    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [31:0] id_upper_reg;
    reg  [31:0] id_lower_reg;
    reg         upper_done_reg;
    reg         lower_done_reg;
    reg  [21:0] rom_base_reg;
    reg         eeprom_load_d_reg;
    reg         ee_take_reg;
    reg  [31:0] status_word;

    wire [SYNC_W-1:0] pin_vec;
    wire [SYNC_W-1:0] pin_sync;
    wire [63:0]       ee_id_s;
    wire              bus_rst_s;
    wire              eeprom_s;
    wire              load_s;
    wire              ee_pulse;
    wire              fw_upper;
    wire              fw_lower;

    // Every pin level passes two flip-flops; the identifier bits travel
    // with the strobe so both arrive with the same delay
    assign pin_vec = {eeprom_id_i, eeprom_load_i, eeprom_present_i,
                      bus_reset_in_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            reg meta_reg;
            reg safe_reg;
            always @(posedge clk_sys_i) begin
                if (reset_i) begin
                    meta_reg <= 1'b0;
                    safe_reg <= 1'b0;
                end else begin
                    meta_reg <= pin_vec[gi];
                    safe_reg <= meta_reg;
                end
            end
            assign pin_sync[gi] = safe_reg;
        end
    endgenerate

    assign bus_rst_s = pin_sync[0];
    assign eeprom_s  = pin_sync[1];
    assign load_s    = pin_sync[2];
    assign ee_id_s   = pin_sync[SYNC_W-1:3];
    // Loader data must be stable while its strobe is high; the capture
    // waits one cycle past the synchronised edge, so a data bit that
    // resolves a cycle later than the strobe is still taken correctly
    assign ee_pulse  = load_s & ~eeprom_load_d_reg;

    // Firmware writes count only when no EEPROM is fitted
    assign fw_upper = (state_reg == ST_LOAD) & ~eeprom_s & reg_wr_i &
                      (reg_addr_i == `NGRM_OFS_ID_UPPER) & ~upper_done_reg;
    assign fw_lower = (state_reg == ST_LOAD) & ~eeprom_s & reg_wr_i &
                      (reg_addr_i == `NGRM_OFS_ID_LOWER) & ~lower_done_reg;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (bus_rst_s) begin
                    state_next = ST_ARM;
                end
            end
            ST_ARM: begin
                // Loading starts only once bus reset has deasserted
                if (!bus_rst_s) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (eeprom_s && ee_take_reg) begin
                    state_next = ST_LOCK;
                end else if ((upper_done_reg | fw_upper) &&
                             (lower_done_reg | fw_lower)) begin
                    state_next = ST_LOCK;
                end
            end
            // Only a hardware reset leaves here; later bus resets must
            // not reopen the load window
            ST_LOCK: begin
                state_next = ST_LOCK;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg         <= ST_IDLE;
            id_upper_reg      <= `NGRM_ID_RESET;
            id_lower_reg      <= `NGRM_ID_RESET;
            upper_done_reg    <= 1'b0;
            lower_done_reg    <= 1'b0;
            rom_base_reg      <= `NGRM_ROM_MAP_RESET;
            eeprom_load_d_reg <= 1'b0;
            ee_take_reg       <= 1'b0;
        end else begin
            state_reg         <= state_next;
            eeprom_load_d_reg <= load_s;
            ee_take_reg       <= ee_pulse;
            if ((state_reg == ST_LOAD) && eeprom_s && ee_take_reg) begin
                id_upper_reg <= ee_id_s[63:32];
                id_lower_reg <= ee_id_s[31:0];
            end
            // Writes outside the load window fall through untouched.
            // Each firmware word is taken once; the done flags keep a
            // second write to the same word from replacing the first
            if (fw_upper) begin
                id_upper_reg   <= reg_wdata_i;
                upper_done_reg <= 1'b1;
            end
            if (fw_lower) begin
                id_lower_reg   <= reg_wdata_i;
                lower_done_reg <= 1'b1;
            end
            // Only the base field is stored; the low ten bits read zero
            if (reg_wr_i && (reg_addr_i == `NGRM_OFS_ROM_MAP)) begin
                rom_base_reg <= reg_wdata_i[31:`NGRM_ROM_BASE_LSB];
            end
        end
    end

    // Status bits sit at fixed positions; all other bits read zero
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`NGRM_STAT_LOCKED] = (state_reg == ST_LOCK);
        status_word[`NGRM_STAT_EEPROM] = eeprom_s;
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `NGRM_OFS_ID_UPPER: reg_rdata_o <= id_upper_reg;
                `NGRM_OFS_ID_LOWER: reg_rdata_o <= id_lower_reg;
                `NGRM_OFS_ROM_MAP:
                    reg_rdata_o <= {rom_base_reg, 10'h000};
                `NGRM_OFS_LOAD_STATUS:
                    reg_rdata_o <= status_word;
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Lock flag comes straight from the state register, free of glitches
    assign id_locked_o = (state_reg == ST_LOCK);
    assign unique_id_o = {id_upper_reg, id_lower_reg};

    ngrm_rom_map u_rom_map (
        .clk_sys_i        (clk_sys_i),
        .reset_i          (reset_i),
        .rom_image_base_i (rom_base_reg),
        .req_valid_i      (req_valid_i),
        .req_quadlet_i    (req_quadlet_i),
        .req_offset_i     (req_offset_i),
        .map_valid_o      (map_valid_o),
        .map_addr_o       (map_addr_o)
    );

endmodule
`default_nettype wire

// >>> testbench/ngrm_checker.sv
// Assertions on the identifier and ROM map register bank ports
`timescale 1ns/100ps
`default_nettype none
module ngrm_checker (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        req_valid_i,
    input wire logic        req_quadlet_i,
    input wire logic [47:0] req_offset_i,
    input wire logic        map_valid_o,
    input wire logic [31:0] map_addr_o,
    input wire logic        id_locked_o,
    input wire logic [63:0] unique_id_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // Window check is on offset bits 47..10 only
    wire win = req_valid_i && req_quadlet_i &&
               req_offset_i[47:10] == 38'h3f_fffc_0001;
    sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
    sequence s_win; win; endsequence
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
        else $error("read data outside answer cycle");
    a_upper_read: assert property (s_rd(8'h24) |=>
        reg_rdata_o == $past(unique_id_o[63:32])) else $error("bad upper");
    a_lower_read: assert property (s_rd(8'h28) |=>
        reg_rdata_o == $past(unique_id_o[31:0])) else $error("bad lower");
    a_rom_low_zero: assert property (s_rd(8'h34) |=>
        reg_rdata_o[9:0] == 0) else $error("map low bits set");
    a_id_lock_hold: assert property (id_locked_o |=>
        id_locked_o && $stable(unique_id_o)) else $error("locked id moved");
    a_reset_clear: assert property ($past(reset_i) |->
        unique_id_o == 0 && !id_locked_o) else $error("id not cleared");
    a_map_hit: assert property (s_win |=> map_valid_o &&
        map_addr_o[9:0] == $past(req_offset_i[9:0])) else $error("bad map");
    a_map_miss: assert property (!win |=> !map_valid_o)
        else $error("map outside window");
endmodule
`default_nettype wire

// >>> testbench/ngrm_ldr_model.sv
// Bus reset and EEPROM loader model facing the register bank
`timescale 1ns/100ps
`default_nettype none
module ngrm_ldr_model (
    input  wire logic        clk_sys_i,
    output var  logic        bus_reset_in_o = 1'b0,
    output var  logic        eeprom_present_o = 1'b0,
    output var  logic        eeprom_load_o = 1'b0,
    output var  logic [63:0] eeprom_id_o = 64'h0
);
    task automatic set_present(input logic p);
        @(posedge clk_sys_i) eeprom_present_o <= p;
    endtask
    task automatic bus_reset();
        @(posedge clk_sys_i) bus_reset_in_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        bus_reset_in_o <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic load(input logic [63:0] id);
        @(posedge clk_sys_i) eeprom_id_o <= id;
        eeprom_load_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        eeprom_load_o <= 1'b0;
        // Data is held one cycle after the load strobe drops, then changes
        @(posedge clk_sys_i) eeprom_id_o <= ~id;
        repeat (4) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the identifier and ROM map register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        req_quadlet_i = 1'b0;
    logic [47:0] req_offset_i = 48'h0;
    wire  [31:0] reg_rdata_o, map_addr_o;
    wire  [63:0] eeprom_id_i, unique_id_o;
    wire         bus_reset_in_i, eeprom_present_i, eeprom_load_i;
    wire         map_valid_o, id_locked_o;
    int          failures = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    ngrm_regs i_dut (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_reset_in_i,
        .eeprom_present_i, .eeprom_load_i, .eeprom_id_i, .req_valid_i,
        .req_quadlet_i, .req_offset_i, .map_valid_o, .map_addr_o,
        .id_locked_o, .unique_id_o);
    ngrm_ldr_model i_ldr (.clk_sys_i, .bus_reset_in_o(bus_reset_in_i),
        .eeprom_present_o(eeprom_present_i), .eeprom_load_o(eeprom_load_i),
        .eeprom_id_o(eeprom_id_i));
    task automatic chk(input string n, input logic [63:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk("read data", e, reg_rdata_o);
    endtask
    task automatic req(input logic [47:0] o, input logic q, v,
                       input logic [31:0] e);
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_quadlet_i <= q;
        req_offset_i <= o;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        #1 chk("map valid", v, map_valid_o);
        if (v) chk("map address", e, map_addr_o);
    endtask
    task automatic test_firmware();
        rd(8'h28, 32'h0);
        wr(8'h24, 32'h5a5a_0001);
        rd(8'h24, 32'h0);
        i_ldr.bus_reset();
        wr(8'h24, 32'h1234_5678);
        wr(8'h28, 32'h9abc_def0);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("locked", 1, id_locked_o);
        chk("id", 64'h1234_5678_9abc_def0, unique_id_o);
        rd(8'h30, 32'h0000_0001);
        wr(8'h24, 32'h0);
        i_ldr.bus_reset();
        wr(8'h28, 32'h0);
        rd(8'h24, 32'h1234_5678);
        rd(8'h28, 32'h9abc_def0);
        rd(8'h3c, 32'h0);
    endtask
    task automatic test_rom();
        wr(8'h34, 32'h8000_07ff);
        rd(8'h34, 32'h8000_0400);
        req(48'hffff_f000_0404, 1'b1, 1'b1, 32'h8000_0404);
        req(48'hffff_f000_07ff, 1'b1, 1'b1, 32'h8000_07ff);
        req(48'hffff_f000_0800, 1'b1, 1'b0, 32'h0);
        req(48'hffff_f000_03ff, 1'b1, 1'b0, 32'h0);
        req(48'hffff_f000_0404, 1'b0, 1'b0, 32'h0);
    endtask
    task automatic test_eeprom();
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(8'h24, 32'h0);
        rd(8'h34, 32'h0);
        i_ldr.set_present(1'b1);
        i_ldr.bus_reset();
        wr(8'h24, 32'h0bad_0bad);
        i_ldr.load(64'hfeed_c0de_0000_0042);
        chk("id", 64'hfeed_c0de_0000_0042, unique_id_o);
        rd(8'h28, 32'h0000_0042);
        rd(8'h30, 32'h0000_0003);
        i_ldr.load(64'h0);
        chk("id", 64'hfeed_c0de_0000_0042, unique_id_o);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Whole run needs about 120 cycles; the ceiling leaves wide margin
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        test_firmware();
        test_rom();
        test_eeprom();
        report_and_stop();
    end
endmodule
bind ngrm_regs ngrm_checker i_chk (.clk_sys_i, .reset_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .req_valid_i, .req_quadlet_i, .req_offset_i,
    .map_valid_o, .map_addr_o, .id_locked_o, .unique_id_o);
`default_nettype wire
